// ===== design/fied_pkg.sv
package fied_pkg;

  // bus and register map (byte addresses)
  localparam int          AW            = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_RISE_EN   = 8'h04;
  localparam logic [7:0]  OFS_FALL_EN   = 8'h08;
  localparam logic [7:0]  OFS_SHORT_EN  = 8'h0C;
  localparam logic [7:0]  OFS_BREAK_EN  = 8'h10;
  localparam logic [7:0]  OFS_STATE     = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1C;
  localparam logic [7:0]  OFS_FRAME     = 8'h20;
  localparam logic [7:0]  OFS_FRAME_END = 8'h3C;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // control register fields
  localparam int          CTRL_SEL_LSB  = 0;
  localparam int          CTRL_SEL_MSB  = 1;
  localparam int          CTRL_DIAG_IE  = 2;
  localparam int          CTRL_HW_IE    = 3;
  localparam int          CTRL_EXT_DIAG = 4;
  localparam int          CTRL_W        = 5;
  localparam logic [4:0]  CTRL_RST      = 5'h01;

  // status layout: rise, fall, short, break bytes
  localparam int          ST_RISE       = 0;
  localparam int          ST_FALL       = 8;
  localparam int          ST_SHORT      = 16;
  localparam int          ST_BREAK      = 24;

  // filter delays
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          US_PER_S      = 1_000_000;
  localparam int          DLY0_US       = 500;
  localparam int          DLY1_US       = 3_000;
  localparam int          DLY2_US       = 15_000;
  localparam int          DLY3_US       = 20_000;
  localparam int          CYC_PER_US    = CLK_HZ / US_PER_S;
  localparam int          DLY0_CYC      = DLY0_US * CYC_PER_US;
  localparam int          DLY1_CYC      = DLY1_US * CYC_PER_US;
  localparam int          DLY2_CYC      = DLY2_US * CYC_PER_US;
  localparam int          DLY3_CYC      = DLY3_US * CYC_PER_US;
  localparam int          CNT_W         = 19;

  // diagnostic frame
  localparam logic [7:0]  FRAME_LEN     = 8'h20;
  localparam logic [7:0]  FRAME_TAG     = 8'hA5;  // arbitrary value

  typedef enum logic [1:0] {
    FIED_DLY_0P5, FIED_DLY_3, FIED_DLY_15, FIED_DLY_20
  } fied_dly_t;

endpackage

// ===== design/fied_top.sv
// Summary of operation
// - one filter delay for all channels: 0.5/3/15/20 ms, 3 ms at reset.
// - same filter delay for rising and falling input changes.
// - per-channel rising-edge interrupt enable, off at reset.
// - per-channel falling-edge interrupt enable, off at reset.
// - edge enables written only while module hardware interrupt enabled.
// - per-channel short-to-ground and wire-break enables, off at reset.
// - extended diagnostics on gives a diagnostic frame of 32 bytes.
// - short or break on enabled channel raises its diagnostic interrupt.
`timescale 1ns/1ps
module fied_top #(
  parameter int NCH      = 8,
  parameter int CNT_W    = fied_pkg::CNT_W,
  parameter int DLY0_CYC = fied_pkg::DLY0_CYC,
  parameter int DLY1_CYC = fied_pkg::DLY1_CYC,
  parameter int DLY2_CYC = fied_pkg::DLY2_CYC,
  parameter int DLY3_CYC = fied_pkg::DLY3_CYC
) (
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  input  wire logic [NCH-1:0]         din_in,
  input  wire logic [NCH-1:0]         short_det_in,
  input  wire logic [NCH-1:0]         break_det_in,
  input  wire logic [fied_pkg::AW-1:0] s_axi_awaddr_in,
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [31:0]            s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  output logic [1:0]                  s_axi_bresp_out,
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  input  wire logic [fied_pkg::AW-1:0] s_axi_araddr_in,
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  output logic [31:0]                 s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in,
  output logic [NCH-1:0]              state_out,
  output logic                        irq_out
);

  function automatic logic [CNT_W-1:0] dly_cyc(input logic [1:0] sel);
    case (fied_pkg::fied_dly_t'(sel))
      fied_pkg::FIED_DLY_0P5: dly_cyc = CNT_W'(DLY0_CYC);
      fied_pkg::FIED_DLY_3:   dly_cyc = CNT_W'(DLY1_CYC);
      fied_pkg::FIED_DLY_15:  dly_cyc = CNT_W'(DLY2_CYC);
      default:                dly_cyc = CNT_W'(DLY3_CYC);
    endcase
  endfunction

  function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    wr_merge = res;
  endfunction

  // registers
  logic [fied_pkg::CTRL_W-1:0] ctrl_r;
  logic [NCH-1:0]              rise_en_r;
  logic [NCH-1:0]              fall_en_r;
  logic [NCH-1:0]              short_en_r;
  logic [NCH-1:0]              break_en_r;
  logic [31:0]                 stat_r;
  logic [31:0]                 mask_r;

  // input synchronisers, 3 stages plus agreed value
  localparam int SW = 3 * NCH;
  logic [SW-1:0]               sy1_r;
  logic [SW-1:0]               sy2_r;
  logic [SW-1:0]               sy3_r;
  logic [SW-1:0]               syq_r;
  wire  [SW-1:0]               sy_agree = ~(sy2_r ^ sy3_r);
  wire  [SW-1:0]               syq_nxt  = (sy_agree & sy3_r)
                                        | (~sy_agree & syq_r);
  wire  [NCH-1:0]              din_q    = syq_r[NCH-1:0];
  wire  [NCH-1:0]              short_q  = syq_r[2*NCH-1:NCH];
  wire  [NCH-1:0]              break_q  = syq_r[SW-1:2*NCH];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      syq_r <= '0;
    end else begin
      sy1_r <= {break_det_in, short_det_in, din_in};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      syq_r <= syq_nxt;
    end
  end

  // debounce filters
  wire  [1:0]       dly_sel = ctrl_r[fied_pkg::CTRL_SEL_MSB:
                                     fied_pkg::CTRL_SEL_LSB];
  wire  [CNT_W-1:0] dly_lim = dly_cyc(dly_sel) - CNT_W'(1);
  logic [CNT_W-1:0] cnt_r [NCH];
  logic [CNT_W-1:0] cnt_nxt [NCH];
  logic [NCH-1:0]   filt_r;
  logic [NCH-1:0]   accept;

  for (genvar i = 0; i < NCH; i++) begin : g_filt
    // one counter for either direction of change
    assign accept[i]  = (din_q[i] != filt_r[i])
                      && (cnt_r[i] >= dly_lim);
    assign cnt_nxt[i] = ((din_q[i] == filt_r[i]) || accept[i]) ? '0
                      : cnt_r[i] + CNT_W'(1);
  end

  wire [NCH-1:0] filt_nxt = filt_r ^ accept;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      filt_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      filt_r <= filt_nxt;
      for (int i = 0; i < NCH; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  // events
  wire           hw_ie    = ctrl_r[fied_pkg::CTRL_HW_IE];
  wire           diag_ie  = ctrl_r[fied_pkg::CTRL_DIAG_IE];
  wire           ext_diag = ctrl_r[fied_pkg::CTRL_EXT_DIAG];
  wire [NCH-1:0] rise_ev  = accept & ~filt_r & rise_en_r
                          & {NCH{hw_ie}};
  wire [NCH-1:0] fall_ev  = accept & filt_r & fall_en_r
                          & {NCH{hw_ie}};
  wire [NCH-1:0] short_on = short_q & short_en_r;
  wire [NCH-1:0] break_on = break_q & break_en_r;
  logic [NCH-1:0] short_on_r;
  logic [NCH-1:0] break_on_r;
  wire [NCH-1:0] short_ev = short_on & ~short_on_r
                          & {NCH{diag_ie}};
  wire [NCH-1:0] break_ev = break_on & ~break_on_r
                          & {NCH{diag_ie}};
  wire [31:0]    stat_set = {break_ev, short_ev, fall_ev, rise_ev};

  // axi4-lite write path
  logic                   aw_full_r;
  logic                   w_full_r;
  logic [fied_pkg::AW-1:0] aw_addr_r;
  logic [31:0]            w_data_r;
  logic [3:0]             w_strb_r;
  wire aw_hs   = s_axi_awvalid_in && s_axi_awready_out;
  wire w_hs    = s_axi_wvalid_in && s_axi_wready_out;
  wire do_wr   = aw_full_r && w_full_r && !s_axi_bvalid_out;
  wire b_done  = s_axi_bvalid_out && s_axi_bready_in;
  wire aw_full_nxt = do_wr ? 1'b0 : (aw_hs ? 1'b1 : aw_full_r);
  wire w_full_nxt  = do_wr ? 1'b0 : (w_hs ? 1'b1 : w_full_r);
  wire bvalid_nxt  = do_wr ? 1'b1 : (b_done ? 1'b0 : s_axi_bvalid_out);

  wire wa_ctrl  = aw_addr_r == fied_pkg::OFS_CTRL;
  wire wa_rise  = aw_addr_r == fied_pkg::OFS_RISE_EN;
  wire wa_fall  = aw_addr_r == fied_pkg::OFS_FALL_EN;
  wire wa_short = aw_addr_r == fied_pkg::OFS_SHORT_EN;
  wire wa_brk   = aw_addr_r == fied_pkg::OFS_BREAK_EN;
  wire wa_stat  = aw_addr_r == fied_pkg::OFS_IRQ_STAT;
  wire wa_mask  = aw_addr_r == fied_pkg::OFS_IRQ_MASK;
  wire wa_ro    = (aw_addr_r == fied_pkg::OFS_STATE)
               || ((aw_addr_r >= fied_pkg::OFS_FRAME)
               && (aw_addr_r <= fied_pkg::OFS_FRAME_END));
  wire wa_ok    = (wa_ctrl || wa_rise || wa_fall || wa_short || wa_brk
               || wa_stat || wa_mask || wa_ro) && (aw_addr_r[1:0] == 2'h0);

  wire [31:0] wm_ctrl  = wr_merge(32'(ctrl_r), w_data_r, w_strb_r);
  wire [31:0] wm_rise  = wr_merge(32'(rise_en_r), w_data_r, w_strb_r);
  wire [31:0] wm_fall  = wr_merge(32'(fall_en_r), w_data_r, w_strb_r);
  wire [31:0] wm_short = wr_merge(32'(short_en_r), w_data_r, w_strb_r);
  wire [31:0] wm_brk   = wr_merge(32'(break_en_r), w_data_r, w_strb_r);
  wire [31:0] wm_mask  = wr_merge(mask_r, w_data_r, w_strb_r);
  wire [31:0] st_clr   = wr_merge(32'h0000_0000, w_data_r, w_strb_r);

  wire wr_edge_ok = do_wr && hw_ie;
  wire [31:0] clr_v = (do_wr && wa_stat && wa_ok) ? st_clr : 32'h0000_0000;
  // a new event wins over a clear in the same cycle
  wire [31:0] stat_nxt = (stat_r & ~clr_v) | stat_set;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_full_r         <= 1'b0;
      w_full_r          <= 1'b0;
      aw_addr_r         <= '0;
      w_data_r          <= '0;
      w_strb_r          <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= fied_pkg::RESP_OKAY;
    end else begin
      aw_full_r         <= aw_full_nxt;
      w_full_r          <= w_full_nxt;
      s_axi_awready_out <= !aw_full_nxt && !bvalid_nxt;
      s_axi_wready_out  <= !w_full_nxt && !bvalid_nxt;
      s_axi_bvalid_out  <= bvalid_nxt;
      if (aw_hs) begin
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        s_axi_bresp_out <= wa_ok ? fied_pkg::RESP_OKAY
                                 : fied_pkg::RESP_SLVERR;
      end
    end
  end

  // register updates
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_r     <= fied_pkg::CTRL_RST;
      rise_en_r  <= '0;
      fall_en_r  <= '0;
      short_en_r <= '0;
      break_en_r <= '0;
      mask_r     <= '0;
    end else begin
      if (do_wr && wa_ctrl && wa_ok) begin
        ctrl_r <= wm_ctrl[fied_pkg::CTRL_W-1:0];
      end
      if (wr_edge_ok && wa_rise && wa_ok) begin
        rise_en_r <= wm_rise[NCH-1:0];
      end
      if (wr_edge_ok && wa_fall && wa_ok) begin
        fall_en_r <= wm_fall[NCH-1:0];
      end
      if (do_wr && wa_short && wa_ok) begin
        short_en_r <= wm_short[NCH-1:0];
      end
      if (do_wr && wa_brk && wa_ok) begin
        break_en_r <= wm_brk[NCH-1:0];
      end
      if (do_wr && wa_mask && wa_ok) begin
        mask_r <= wm_mask;
      end
    end
  end

  // status, interrupt and visible state
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stat_r     <= '0;
      short_on_r <= '0;
      break_on_r <= '0;
      state_out  <= '0;
      irq_out    <= 1'b0;
    end else begin
      stat_r     <= stat_nxt;
      short_on_r <= short_on;
      break_on_r <= break_on;
      state_out  <= filt_nxt;
      irq_out    <= |(stat_nxt & mask_r);
    end
  end

  // diagnostic frame: 8 words, 32 bytes
  wire [NCH-1:0] err_map = short_on | break_on;
  wire [31:0] frm_w0 = {8'(err_map), fied_pkg::FRAME_TAG,
                        8'(ctrl_r), fied_pkg::FRAME_LEN};
  wire [2:0]  frm_idx = s_axi_araddr_in[4:2];
  logic [31:0] frm_word;
  always_comb begin
    case (frm_idx)
      3'h0:    frm_word = frm_w0;
      3'h1:    frm_word = 32'(filt_r);
      3'h2:    frm_word = 32'(short_on);
      3'h3:    frm_word = 32'(break_on);
      3'h4:    frm_word = 32'(short_en_r);
      3'h5:    frm_word = 32'(break_en_r);
      3'h6:    frm_word = stat_r;
      default: frm_word = 32'(err_map);
    endcase
  end

  // axi4-lite read path
  wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  wire r_done = s_axi_rvalid_out && s_axi_rready_in;
  wire rvalid_nxt = ar_hs ? 1'b1 : (r_done ? 1'b0 : s_axi_rvalid_out);
  wire [fied_pkg::AW-1:0] ra = s_axi_araddr_in;
  wire ra_al = ra[1:0] == 2'h0;
  wire ra_frm = (ra >= fied_pkg::OFS_FRAME)
             && (ra <= fied_pkg::OFS_FRAME_END);
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = ra_al;
    rd_val = 32'h0000_0000;
    if (ra == fied_pkg::OFS_CTRL) begin
      rd_val = 32'(ctrl_r);
    end else if (ra == fied_pkg::OFS_RISE_EN) begin
      rd_val = 32'(rise_en_r);
    end else if (ra == fied_pkg::OFS_FALL_EN) begin
      rd_val = 32'(fall_en_r);
    end else if (ra == fied_pkg::OFS_SHORT_EN) begin
      rd_val = 32'(short_en_r);
    end else if (ra == fied_pkg::OFS_BREAK_EN) begin
      rd_val = 32'(break_en_r);
    end else if (ra == fied_pkg::OFS_STATE) begin
      rd_val = 32'(filt_r);
    end else if (ra == fied_pkg::OFS_IRQ_STAT) begin
      rd_val = stat_r;
    end else if (ra == fied_pkg::OFS_IRQ_MASK) begin
      rd_val = mask_r;
    end else if (ra_frm) begin
      rd_val = ext_diag ? frm_word : 32'h0000_0000;
    end else begin
      rd_ok = 1'b0;
    end
    if (!rd_ok) begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= fied_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_out <= !rvalid_nxt;
      s_axi_rvalid_out  <= rvalid_nxt;
      if (ar_hs) begin
        s_axi_rdata_out <= rd_val;
        s_axi_rresp_out <= rd_ok ? fied_pkg::RESP_OKAY
                                 : fied_pkg::RESP_SLVERR;
      end
    end
  end

endmodule // fied_top

// ===== dv/fied_chk.sv
`timescale 1ns/1ps
module fied_chk #(
  parameter int NCH = 8
) (
  input wire logic           clk_in,
  input wire logic           resetn_in,
  input wire logic [NCH-1:0] din_in,
  input wire logic           s_axi_awvalid_in,
  input wire logic           s_axi_awready_out,
  input wire logic           s_axi_wvalid_in,
  input wire logic           s_axi_wready_out,
  input wire logic           s_axi_bvalid_out,
  input wire logic           s_axi_bready_in,
  input wire logic           s_axi_arvalid_in,
  input wire logic           s_axi_arready_out,
  input wire logic           s_axi_rvalid_out,
  input wire logic [31:0]    s_axi_rdata_out,
  input wire logic [1:0]     s_axi_rresp_out,
  input wire logic           s_axi_rready_in,
  input wire logic [NCH-1:0] state_out,
  input wire logic           irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_wtake;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out;
  endsequence
  sequence s_bdone;
    s_axi_bvalid_out && s_axi_bready_in;
  endsequence
  property p_wr_lat;
    s_wtake |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_done;
    s_bdone |=> !s_axi_bvalid_out ##1 (s_axi_awready_out && s_axi_wready_out);
  endproperty
  a_b_done: assert property (p_b_done) else $error("write ready not back");
  property p_rd_lat;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out
      && !s_axi_arready_out;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_done;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out
      && s_axi_arready_out;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read ready not back");
  property p_aw_blk;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_aw_blk: assert property (p_aw_blk) else $error("write taken early");
  property p_rv_err;
    s_axi_rvalid_out && s_axi_rresp_out != 2'h0 |-> s_axi_rdata_out == '0;
  endproperty
  a_rv_err: assert property (p_rv_err) else $error("error read not zero");
  property p_flt;
    !$stable(state_out) |-> ((state_out ^ $past(state_out))
      & (state_out ^ $past(din_in, 3))) == '0;
  endproperty
  a_flt: assert property (p_flt)
    else $error("state took short pulse");
  property p_irq_fall;
    $fell(irq_out) |-> $past(s_axi_wvalid_in && s_axi_wready_out, 2)
      || $past(s_axi_wvalid_in && s_axi_wready_out, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped alone");
endmodule // fied_chk
bind fied_top fied_chk #(.NCH(NCH)) chk_u (.clk_in(clk_in),
  .resetn_in(resetn_in), .din_in(din_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rready_in(s_axi_rready_in), .state_out(state_out),
  .irq_out(irq_out));

// ===== dv/fied_mst.sv
`timescale 1ns/1ps
module fied_mst (
  input  wire logic        clk_in,
  output logic [7:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  output logic [7:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  initial {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out,
           araddr_out, arvalid_out, rready_out} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_in);
    awaddr_out  <= a;
    wdata_out   <= d;
    awvalid_out <= 1'b1;
    wvalid_out  <= 1'b1;
    bready_out  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (awready_in && !ad) begin
        awvalid_out <= 1'b0;
        ad = 1'b1;
      end
      if (wready_in && !wd) begin
        wvalid_out <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge clk_in); while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_in);
    araddr_out  <= a;
    arvalid_out <= 1'b1;
    rready_out  <= 1'b1;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    do @(posedge clk_in); while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule // fied_mst

// ===== dv/filtered_input_edge_diag_tb.sv
`timescale 1ns/1ps
module filtered_input_edge_diag_tb;
  localparam int DLY [4] = '{5, 10, 20, 30};
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  din = 8'h00;
  logic [7:0]  sdet = 8'h00;
  logic [7:0]  bdet = 8'h00;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0]  br, rr;
  logic        awv, awr, wv, wr_, bv, brd, arv, arr, rv, rrd, irq;
  logic [7:0]  st;
  int          miscompares = 0;
  int          num_checks = 0;
  always #25 clk_in = ~clk_in;
  fied_top #(.DLY0_CYC(5), .DLY1_CYC(10), .DLY2_CYC(20),
    .DLY3_CYC(30)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .din_in(din),
    .short_det_in(sdet), .break_det_in(bdet), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrd), .state_out(st), .irq_out(irq));
  fied_mst mst_u (.clk_in(clk_in), .awaddr_out(awa), .awvalid_out(awv),
    .awready_in(awr), .wdata_out(wd), .wvalid_out(wv), .wready_in(wr_),
    .bresp_in(br), .bvalid_in(bv), .bready_out(brd), .araddr_out(ara),
    .arvalid_out(arv), .arready_in(arr), .rdata_in(rdt), .rresp_in(rr),
    .rvalid_in(rv), .rready_out(rrd));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic [1:0] r;
    mst_u.wr(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    mst_u.rd(a, d, r);
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", e, d);
  endtask
  task automatic tog(input logic [7:0] m, output int n);
    n = 0;
    @(posedge clk_in);
    din <= din ^ m;
    do begin
      @(posedge clk_in);
      n++;
    end while (st !== din && n < 200);
  endtask
  task automatic t_filter;
    int n;
    tog(8'h01, n);
    chk("delay_default", 32'h1,
        32'(n >= DLY[1] && n <= DLY[1] + 8));
    for (int s = 0; s < 4; s++) begin
      wr(fied_pkg::OFS_CTRL, 32'(s));
      tog(8'h01, n);
      chk("delay_sel", 32'h1,
          32'(n >= DLY[s] && n <= DLY[s] + 8));
    end
    wr(fied_pkg::OFS_CTRL, 32'h0);
    @(posedge clk_in);
    din <= din ^ 8'h01;
    repeat (2) @(posedge clk_in);
    din <= din ^ 8'h01;
    repeat (20) @(posedge clk_in);
    chk("glitch", 32'h1, {31'h0, st[0]});
  endtask
  task automatic t_edge;
    int n;
    wr(fied_pkg::OFS_RISE_EN, 32'hFF);
    rc(fied_pkg::OFS_RISE_EN, 32'h0);
    wr(fied_pkg::OFS_CTRL, 32'h08);
    wr(fied_pkg::OFS_RISE_EN, 32'h02);
    wr(fied_pkg::OFS_FALL_EN, 32'h01);
    wr(fied_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF);
    tog(8'h03, n);
    rc(fied_pkg::OFS_IRQ_STAT, 32'h102);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(fied_pkg::OFS_IRQ_STAT, 32'h102);
    rc(fied_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    tog(8'h03, n);
    rc(fied_pkg::OFS_IRQ_STAT, 32'h0);
    wr(fied_pkg::OFS_CTRL, 32'h0);
    tog(8'h02, n);
    rc(fied_pkg::OFS_IRQ_STAT, 32'h0);
  endtask
  task automatic t_diag;
    wr(fied_pkg::OFS_SHORT_EN, 32'h04);
    wr(fied_pkg::OFS_BREAK_EN, 32'h08);
    sdet <= 8'h24;
    bdet <= 8'h08;
    rc(fied_pkg::OFS_IRQ_STAT, 32'h0);
    sdet <= 8'h00;
    bdet <= 8'h00;
    wr(fied_pkg::OFS_CTRL, 32'h04);
    sdet <= 8'h24;
    bdet <= 8'h08;
    repeat (6) @(posedge clk_in);
    rc(fied_pkg::OFS_IRQ_STAT, 32'h08040000);
    chk("irq_diag", 32'h1, {31'h0, irq});
    wr(fied_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge clk_in);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(fied_pkg::OFS_IRQ_MASK, 32'h08000000);
    @(posedge clk_in);
    chk("irq_unmask", 32'h1, {31'h0, irq});
  endtask
  task automatic t_frame;
    rc(fied_pkg::OFS_FRAME, 32'h0);
    wr(fied_pkg::OFS_CTRL, 32'h14);
    rc(fied_pkg::OFS_FRAME,
       {8'h0C, fied_pkg::FRAME_TAG, 16'h1420});
    rc(fied_pkg::OFS_FRAME_END, 32'h0C);
    rc(8'h40, 32'h0, fied_pkg::RESP_SLVERR);
    rc(8'h03, 32'h0, fied_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, fied_pkg::RESP_SLVERR);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rc(fied_pkg::OFS_CTRL, {27'h0, fied_pkg::CTRL_RST});
    for (int i = 0; i < 4; i++) begin
      rc(fied_pkg::OFS_RISE_EN + 8'(4 * i), 32'h0);
    end
    t_filter();
    t_edge();
    t_diag();
    t_frame();
    give_verdict();
  end
endmodule // filtered_input_edge_diag_tb
